// file: common/pcv_pkg.sv
// Functional notes
// R1 - link active only with enable set, both pins in mode 01, serial port select set
// R2 - target equals base setting plus N steps while link controls buck
// R3 - N counts link clock rising edges with data sampled high
// R4 - default step is 10 mV per count, N accepted 0 to 32
// R5 - set a and set b ignored while link controls output
// R6 - keep selected set voltage until first full 32-clock frame arrives
// R7 - target updates at end of every full 32-clock frame, latest frame used
// R8 - data rising edge starts a new 32-clock frame
// R9 - early data rising edge discards partial count, previous target kept
// R10 - without edges counting continues; constant low gives base, high gives base plus 32
// R11 - decoded target readable in read-only readback register
// R12 - link ends on enable clear or config change, falls back to chosen set
// R13 - keep-armed clear: buck disable ends link and clears link enable
// R14 - keep-armed set: link survives buck disable, set voltage until first frame
// R15 - double step select gives 20 mV per count
// R16 - target clamped to ceiling setting, over both link and set voltages
// R17 - output above ceiling raises event and alarm unless masked; irq mode instead
// R18 - link pins pass two-stage synchronisers, rising edges detected before use
// R19 - arithmetic in voltage code units, one step one code, double two codes
`default_nettype none
package pcv_pkg;
  localparam int VW = 7;
  localparam logic [4:0]  FRAME_LEN   = 5'h1F;
  localparam logic [1:0]  PIN_IF_MODE = 2'h1;
  localparam int STEP_MV = 10;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_BASE  = 8'h04;
  localparam logic [7:0] A_CEIL  = 8'h08;
  localparam logic [7:0] A_SETA  = 8'h0C;
  localparam logic [7:0] A_SETB  = 8'h10;
  localparam logic [7:0] A_DEC   = 8'h14;
  localparam logic [7:0] A_STAT  = 8'h18;
  localparam logic [7:0] A_MASK  = 8'h1C;
  localparam logic [7:0] A_VOUT  = 8'h20;
  localparam logic [VW-1:0] BASE_RST = 7'h00;
  localparam logic [VW-1:0] CEIL_RST = 7'h7F;
  localparam logic [VW-1:0] SET_RST  = 7'h00;
  localparam logic [1:0]    STAT_RST = 2'h0;
  localparam logic [1:0]    MASK_RST = 2'h0;
  // ctrl bits
  localparam int C_LEN = 0;
  localparam int C_SPS = 1;
  localparam int C_KAR = 2;
  localparam int C_DBL = 3;
  localparam int C_CHS = 4;
  localparam int C_BUCK = 5;
  localparam int C_IRQM = 6;
  localparam int C_P5 = 8;
  localparam int C_P6 = 10;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [11:0] CTRL_WMASK = 12'hF7F;
endpackage
`default_nettype wire

// file: logic/pcv_top.sv
`default_nettype none
module pcv_top
  import pcv_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  input  wire logic          pulse_clock_in_i,
  input  wire logic          pulse_data_in_i,
  output logic [pcv_pkg::VW-1:0] vout_target_o,
  output logic               link_active_o,
  output logic               alarm_output_o,
  output logic               irq_o
);
  import pcv_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic [11:0]   ctrl_q;
  logic [VW-1:0] base_q, ceil_q, seta_q, setb_q;
  logic [1:0]    stat_q, mask_q;
  logic [2:0]    clk_s_q, dat_s_q;
  logic [4:0]    cnt_q;
  logic [5:0]    hits_q;
  logic          valid_q;
  logic [5:0]    n_q;
  logic          act_q;
  logic          buck_q;
  logic [VW-1:0] vout_q;

  wire wr = psel_i & penable_i & pwrite_i;
  wire rd_acc = psel_i & penable_i & ~pwrite_i;
  wire cfg_ok = ctrl_q[C_LEN] & ctrl_q[C_SPS] &
                (ctrl_q[C_P5+:2] == PIN_IF_MODE) & (ctrl_q[C_P6+:2] == PIN_IF_MODE); // R1
  wire buck_fall = buck_q & ~ctrl_q[C_BUCK];

  function automatic logic [VW-1:0] sat_add(input logic [VW-1:0] b, input logic [6:0] d);
    logic [7:0] s;
    s = {1'b0, b} + {1'b0, d};
    sat_add = s[7] ? {VW{1'b1}} : s[VW-1:0];
  endfunction

  function automatic logic [VW-1:0] clamp(input logic [VW-1:0] v, input logic [VW-1:0] c);
    clamp = (v > c) ? c : v;
  endfunction

  ////////////////////////////////////////////////////////////////
  // link pin synchronisers
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clk_s_q <= 3'h0;
      dat_s_q <= 3'h0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[1:0], pulse_clock_in_i}; // R18
      dat_s_q <= {dat_s_q[1:0], pulse_data_in_i}; // R18
    end
  end
  wire clk_rise = clk_s_q[1] & ~clk_s_q[2]; // R18
  wire dat_rise = dat_s_q[1] & ~dat_s_q[2]; // R18
  wire dat_lvl  = dat_s_q[1];

  ////////////////////////////////////////////////////////////////
  // control register, auto clear of link enable
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= CTRL_RST;
      buck_q <= 1'b0;
    end
    else
    begin
      buck_q <= ctrl_q[C_BUCK];
      if (wr && paddr_i == A_CTRL)
        ctrl_q <= pwdata_i[11:0] & CTRL_WMASK;
      else if (buck_fall && !ctrl_q[C_KAR])
        ctrl_q[C_LEN] <= 1'b0; // R13
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      base_q <= BASE_RST;
      ceil_q <= CEIL_RST;
      seta_q <= SET_RST;
      setb_q <= SET_RST;
      mask_q <= MASK_RST;
    end
    else if (wr)
    begin
      if (paddr_i == A_BASE) base_q <= pwdata_i[VW-1:0];
      if (paddr_i == A_CEIL) ceil_q <= pwdata_i[VW-1:0];
      if (paddr_i == A_SETA) seta_q <= pwdata_i[VW-1:0];
      if (paddr_i == A_SETB) setb_q <= pwdata_i[VW-1:0];
      if (paddr_i == A_MASK) mask_q <= pwdata_i[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // frame decoder
  wire lnk_run = cfg_ok & ctrl_q[C_BUCK];
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      act_q <= 1'b0;
      cnt_q <= 5'h0;
      hits_q <= 6'h0;
      valid_q <= 1'b0;
      n_q <= 6'h0;
    end
    else
    begin
      act_q <= lnk_run;
      if (!lnk_run)
      begin
        cnt_q <= 5'h0; // R12
        hits_q <= 6'h0;
        valid_q <= 1'b0; // R6 R14
      end
      else if (dat_rise)
      begin
        // new frame: partial count dropped, old target kept
        cnt_q <= clk_rise ? 5'h1 : 5'h0; // R8 R9
        hits_q <= clk_rise ? 6'h1 : 6'h0;
      end
      else if (clk_rise)
      begin
        if (cnt_q == FRAME_LEN)
        begin
          n_q <= hits_q + {5'h0, dat_lvl}; // R3 R4 R7
          valid_q <= 1'b1;
          cnt_q <= 5'h0; // R10
          hits_q <= 6'h0;
        end
        else
        begin
          cnt_q <= cnt_q + 5'h1;
          hits_q <= hits_q + {5'h0, dat_lvl}; // R3
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // target selection, clamp
  logic [6:0]    delta;
  logic [VW-1:0] dec_v, sel_v, tgt;
  always_comb
  begin
    delta = ctrl_q[C_DBL] ? {n_q, 1'b0} : {1'b0, n_q}; // R15 R19
    dec_v = sat_add(base_q, delta); // R2 R19
    sel_v = ctrl_q[C_CHS] ? setb_q : seta_q; // R12
    tgt = (act_q && valid_q) ? dec_v : sel_v; // R5 R6
    tgt = clamp(tgt, ceil_q); // R16
  end
  wire over = (act_q && valid_q) ? (dec_v > ceil_q) : (sel_v > ceil_q);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      vout_q <= SET_RST;
    else
      vout_q <= tgt;
  end

  ////////////////////////////////////////////////////////////////
  // events: bit0 ceiling exceeded, bit1 first frame decoded after link start
  logic over_q, fr_q;
  wire fr_ev = valid_q & ~fr_q;
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stat_q <= STAT_RST;
      over_q <= 1'b0;
      fr_q <= 1'b0;
    end
    else
    begin
      over_q <= over;
      fr_q <= valid_q;
      for (int i = 0; i < 2; i++)
      begin
        if (i == 0 && over && !over_q)
          stat_q[i] <= 1'b1; // R17
        else if (i == 1 && fr_ev)
          stat_q[i] <= 1'b1;
        else if (wr && paddr_i == A_STAT && pwdata_i[i])
          stat_q[i] <= 1'b0;
      end
    end
  end

  wire pend = |(stat_q & ~mask_q);
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      alarm_output_o <= 1'b0;
      irq_o <= 1'b0;
      vout_target_o <= SET_RST;
      link_active_o <= 1'b0;
    end
    else
    begin
      alarm_output_o <= ~ctrl_q[C_IRQM] & stat_q[0] & ~mask_q[0]; // R17
      irq_o <= ctrl_q[C_IRQM] ? pend : (stat_q[1] & ~mask_q[1]); // R17
      vout_target_o <= vout_q;
      link_active_o <= act_q & valid_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb read path, zero-wait
  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0;
    unique case (paddr_i)
      A_CTRL: rd = {20'h0, ctrl_q};
      A_BASE: rd = {25'h0, base_q};
      A_CEIL: rd = {25'h0, ceil_q};
      A_SETA: rd = {25'h0, seta_q};
      A_SETB: rd = {25'h0, setb_q};
      A_DEC:  rd = {25'h0, clamp(dec_v, ceil_q)}; // R11
      A_STAT: rd = {30'h0, stat_q};
      A_MASK: rd = {30'h0, mask_q};
      A_VOUT: rd = {25'h0, vout_q};
      default: rd = 32'h0;
    endcase
  end
  wire mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= A_VOUT);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      if (psel_i && !penable_i)
        prdata_o <= rd;
      else if (rd_acc)
        prdata_o <= prdata_o;
    end
  end
endmodule
`default_nettype wire

// file: test/pcv_host_model.sv
`default_nettype none
module pcv_host_model (
  output logic pulse_clock_o,
  output logic pulse_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pulse_clock_o = 1'b0;
    pulse_data_o = 1'b0;
  end
  // clock parked low between frames
  task automatic frame(input int highs, input int len);
    #17;
    for (int i = 0; i < len; i++)
    begin
      pulse_data_o = i < highs;
      #200 pulse_clock_o = 1'b1;
      #200 pulse_clock_o = 1'b0;
    end
    pulse_data_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/pcv_sva.sv
`default_nettype none
module pcv_sva
  import pcv_pkg::*;
(
  input wire logic          mclk_i,
  input wire logic          resetn_i,
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire logic [7:0]    paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  input wire logic [VW-1:0] vout_target_o,
  input wire logic          link_active_o,
  input wire logic          alarm_output_o,
  input wire logic          irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0]   ctrl_q;
  logic [VW-1:0] ceil_q;
  logic [1:0]    mask_q;
  logic [1:0]    age_q;
  logic          wr;
  logic          quiet;
  logic          cfg_ok;
  logic          stop_wr;
  ////////////////////////////////////////
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign quiet = age_q == 2'h3;
  assign cfg_ok = ctrl_q[C_LEN] && ctrl_q[C_SPS] && ctrl_q[C_BUCK]
    && ctrl_q[9:8] == PIN_IF_MODE && ctrl_q[11:10] == PIN_IF_MODE;
  assign stop_wr = wr && paddr_i == A_CTRL
    && (!pwdata_i[C_LEN] || !pwdata_i[C_BUCK] && !pwdata_i[C_KAR]);
  // shadow of written settings, age since last write
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      ctrl_q <= CTRL_RST;
      ceil_q <= CEIL_RST;
      mask_q <= MASK_RST;
      age_q <= 2'h0;
    end
    else
    begin
      age_q <= wr ? 2'h0 : age_q + 2'(age_q != 2'h3);
      if (wr && paddr_i == A_CTRL)
        ctrl_q <= pwdata_i[11:0] & CTRL_WMASK;
      if (wr && paddr_i == A_CEIL)
        ceil_q <= pwdata_i[VW-1:0];
      if (wr && paddr_i == A_MASK)
        mask_q <= pwdata_i[1:0];
    end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_bad_read;
    psel_i && !penable_i && !pwrite_i && paddr_i > A_VOUT;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_unmapped_error: assert property (s_bad_read |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_link_needs_cfg: assert property (quiet && !cfg_ok |-> !link_active_o)
    else $error("link active without setup");
  a_link_stop: assert property (stop_wr |-> ##[1:4] !link_active_o)
    else $error("link kept after stop");
  a_ceiling_clamp: assert property (quiet |-> vout_target_o <= ceil_q)
    else $error("target above ceiling");
  a_alarm_irq_mode: assert property (quiet && ctrl_q[C_IRQM] |-> !alarm_output_o)
    else $error("alarm in irq mode");
  a_alarm_masked: assert property (quiet && mask_q[0] |-> !alarm_output_o)
    else $error("masked alarm raised");
  a_irq_masked: assert property (quiet && mask_q == 2'h3 |-> !irq_o)
    else $error("masked irq raised");
endmodule
bind pcv_top pcv_sva u_sva (.*);
`default_nettype wire

// file: test/test_pulse_count_voltage_decoder.sv
`default_nettype none
module test_pulse_count_voltage_decoder;
  import pcv_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic          mclk_i = 1'b0;
  logic          resetn_i = 1'b0;
  logic          psel = 1'b0;
  logic          pen = 1'b0;
  logic          pwr = 1'b0;
  logic [7:0]    pa = 8'h00;
  logic [31:0]   pwd = 32'h0;
  logic [31:0]   prd, rd;
  logic          rdy, err, e, lclk, ldat, act, alm, irq;
  logic [VW-1:0] vout;
  int            num_errors = 0;
  int            comparisons = 0;
  ////////////////////////////////////////
  always #25 mclk_i = ~mclk_i;
  pcv_host_model u_host (.pulse_clock_o(lclk), .pulse_data_o(ldat));
  pcv_top dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .pulse_clock_in_i(lclk), .pulse_data_in_i(ldat),
    .vout_target_o(vout), .link_active_o(act), .alarm_output_o(alm), .irq_o(irq));
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    for (int n = 0; n < 9 && rdy !== 1'b1; n++)
      @(posedge mclk_i);
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (rdy !== 1'b1)
    begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic vwait(input logic [VW-1:0] x);
    for (int n = 0; n < 40 && vout !== x; n++)
      @(posedge mclk_i);
    check(vout, x);
    if (vout !== x)
      finish_test();
  endtask
  task automatic hold(input logic [VW-1:0] x);
    repeat (12) @(posedge mclk_i);
    check(vout, x);
  endtask
  task automatic t_regs();
    apb(0, A_CEIL, 0);
    check(rd, 32'h7F);
    apb(0, 8'h24, 0);
    check(e, 1'b1);
    check(rd, 32'h0);
    apb(1, 8'h26, 32'h1);
    check(e, 1'b1);
    apb(0, A_CTRL, 0);
    check(rd, 32'h0);
    apb(1, A_DEC, 32'h55);
    apb(0, A_DEC, 0);
    check(rd, 32'h0);
  endtask
  task automatic t_link();
    apb(1, A_BASE, 32'h10);
    apb(1, A_SETA, 32'h05);
    apb(1, A_SETB, 32'h09);
    apb(1, A_CTRL, 32'h123);
    u_host.frame(3, 32);
    hold(7'h05);
    check(act, 1'b0);
    apb(1, A_CTRL, 32'h523);
    hold(7'h05);
    u_host.frame(16, 32);
    vwait(7'h20);
    apb(0, A_DEC, 0);
    check(rd, 32'h20);
    apb(1, A_SETA, 32'h07);
    hold(7'h20);
    u_host.frame(3, 10);
    hold(7'h20);
    u_host.frame(4, 32);
    vwait(7'h14);
    apb(1, A_CTRL, 32'h522);
    vwait(7'h07);
    check(act, 1'b0);
  endtask
  task automatic t_step();
    apb(1, A_CTRL, 32'h52B);
    u_host.frame(16, 32);
    vwait(7'h30);
    apb(1, A_CEIL, 32'h28);
    vwait(7'h28);
    repeat (3) @(posedge mclk_i);
    check(alm, 1'b1);
    check(irq, 1'b1);
    apb(0, A_STAT, 0);
    check(rd, 32'h3);
    apb(1, A_MASK, 32'h3);
    repeat (3) @(posedge mclk_i);
    check({alm, irq}, 2'h0);
    apb(1, A_STAT, 32'h3);
    apb(0, A_STAT, 0);
    check(rd, 32'h0);
    apb(1, A_CTRL, 32'h523);
    apb(1, A_CEIL, 32'h7F);
    u_host.frame(32, 32);
    vwait(7'h30);
  endtask
  task automatic t_arm();
    apb(1, A_CTRL, 32'h527);
    apb(1, A_CTRL, 32'h507);
    apb(1, A_CTRL, 32'h537);
    hold(7'h09);
    u_host.frame(5, 32);
    vwait(7'h15);
    apb(1, A_CTRL, 32'h573);
    apb(1, A_CTRL, 32'h553);
    apb(0, A_CTRL, 0);
    check(rd, 32'h552);
    apb(1, A_MASK, 32'h0);
    repeat (3) @(posedge mclk_i);
    check(irq, 1'b1);
    check(alm, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_link();
    t_step();
    t_arm();
    finish_test();
  end
endmodule
`default_nettype wire
